/* File: src/mbad_pkg.sv */
// mbad_pkg: constants and types for the processor bus and address decoder
// assumes one 100 MHz system clock; every slower rate is an enable pulse
package mbad_pkg;
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned XTAL_HZ     = 4_000_000;
	localparam int unsigned DIV_4M      = CLK_HZ / XTAL_HZ;
	localparam logic [4:0]  DIV_4M_MAX  = 5'(DIV_4M - 1);
	localparam int unsigned POR_TIME_US = 10;
	localparam logic [7:0]  POR_TICKS   = 8'((POR_TIME_US * XTAL_HZ + 999_999) / 1_000_000);
	localparam logic [15:0] VEC_RESET   = 16'hFFFE;
	localparam logic [15:0] VEC_NMI     = 16'hFFFC;
	localparam logic [15:0] VEC_IRQ     = 16'hFFF8;
	localparam logic [15:0] ADDR_HIGH   = 16'hFFFF;
	localparam logic [15:0] RAM_LO      = 16'h6080;
	localparam logic [15:0] RAM_HI      = 16'h60FF;
	localparam logic [15:0] DEV_BASE    = 16'h0010;
	localparam logic [15:0] KEYPAD_ADDR = 16'h0010;
	localparam logic [15:0] FREE_START  = 16'h8000;
	localparam logic [7:0]  CLB_FORCE   = 8'hA0;
	localparam logic [2:0]  STACK_LAST  = 3'h6;
	localparam logic [1:0]  Q_PHI1      = 2'h0;
	localparam logic [1:0]  Q_PHI2      = 2'h2;
	localparam logic [1:0]  Q_END       = 2'h3;

	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_VEC   = 3'b001,
		ST_RUN   = 3'b010,
		ST_STACK = 3'b011,
		ST_FREE  = 3'b100
	} mbad_state_t;

	typedef struct packed {
		logic        write;
		logic        last;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mbad_req_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] ix;
		logic [15:0] sp;
		logic [7:0]  acca;
		logic [7:0]  accb;
		logic [7:0]  ccr;
	} mbad_regs_t;
endpackage

/* File: src/mbad_clkgen.sv */
// mbad_clkgen: 4 MHz enable, two-phase 1 MHz clock and power-up reset
// assumes clk_i is the 100 MHz system clock
`timescale 1ns/1ps
module mbad_clkgen
	import mbad_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// phase timing
	output logic            tick_o,
	output logic [1:0]      qtr_o,
	output logic            phi1_o,
	output logic            phi2_o,
	// power-up
	output logic            por_n_o,
	output logic            display_blank_reset_o
);
	logic [4:0] div_reg;
	logic [7:0] por_cnt_reg;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_reg <= 5'h0;
			tick_o  <= 1'b0;
		end else begin
			tick_o  <= (div_reg == DIV_4M_MAX);
			div_reg <= (div_reg == DIV_4M_MAX) ? 5'h0 : div_reg + 5'h1;
		end
	end

	// gaps at quarters 1 and 3 keep the phases from overlapping
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			qtr_o  <= Q_END;
			phi1_o <= 1'b0;
			phi2_o <= 1'b0;
		end else if (div_reg == DIV_4M_MAX) begin
			qtr_o  <= qtr_o + 2'h1;
			phi1_o <= (qtr_o == Q_END);
			phi2_o <= (qtr_o == 2'h1);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			por_cnt_reg           <= 8'h0;
			por_n_o               <= 1'b0;
			display_blank_reset_o <= 1'b1;
		end else if (div_reg == DIV_4M_MAX && !por_n_o) begin
			por_cnt_reg           <= por_cnt_reg + 8'h1;
			por_n_o               <= (por_cnt_reg == POR_TICKS - 8'h1);
			display_blank_reset_o <= (por_cnt_reg != POR_TICKS - 8'h1);
		end
	end
endmodule

/* File: src/mbad_top.sv */
// mbad_top: processor bus sequencer, interrupt entry and address decoder
// assumes a core drives one bus request per 1 MHz cycle on the user side
`timescale 1ns/1ps
module mbad_top
	import mbad_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// processor control inputs
	input  wire logic        cpu_reset_n_i,
	input  wire logic        processor_stop_i,
	input  wire logic        three_state_ctrl_i,
	input  wire logic        data_bus_drive_enable_i,
	input  wire logic        nonmaskable_interrupt_n_i,
	input  wire logic        interrupt_request_n_i,
	// test straps
	input  wire logic        free_run_test_n_i,
	input  wire logic        external_rom_select_n_i,
	// core side
	input  wire logic        req_valid_i,
	input  wire mbad_req_t   req_i,
	input  wire mbad_regs_t  regs_i,
	input  wire logic        mask_clear_i,
	output logic             req_taken_o,
	output logic             rsp_valid_o,
	output logic [7:0]       rsp_data_o,
	output logic             pc_load_valid_o,
	output logic [15:0]      pc_load_o,
	output logic             mask_o,
	// clocks and power-up
	output logic             phi1_o,
	output logic             phi2_o,
	output logic             cpu_reset_n_o,
	output logic             display_blank_reset_o,
	// processor bus
	output logic [15:0]      addr_n_o,
	output logic             valid_address_strobe_o,
	output logic             rw_o,
	output logic             rw_oe_o,
	input  wire logic [7:0]  data_i,
	output logic [7:0]       data_o,
	output logic             data_oe_o,
	// transceiver and memory selects
	output logic             xcvr_en_n_o,
	output logic             xcvr_dir_o,
	output logic             ram_sel_n_o,
	output logic             rom_sel_n_o,
	// device strobes
	output logic [7:0]       dev_rd_n_o,
	output logic [7:0]       dev_wr_n_o,
	output logic             keypad_read_strobe_n_o
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic is_ram(input logic [15:0] a);
		is_ram = (a >= RAM_LO) && (a <= RAM_HI);
	endfunction

	function automatic logic is_dev(input logic [15:0] a);
		is_dev = (a[15:3] == DEV_BASE[15:3]);
	endfunction

	function automatic logic is_rom(input logic [15:0] a, input logic ext_n);
		is_rom = a[15] && ext_n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic        tick;
	logic [1:0]  qtr;
	logic        por_n;
	logic        cyc_start;
	logic        cyc_phi2;
	logic        cyc_end;

	mbad_clkgen u_clkgen (
		.clk_i                 (clk_i),
		.sys_rst_i             (sys_rst_i),
		.tick_o                (tick),
		.qtr_o                 (qtr),
		.phi1_o                (phi1_o),
		.phi2_o                (phi2_o),
		.por_n_o               (por_n),
		.display_blank_reset_o (display_blank_reset_o)
	);

	assign cyc_start = tick && (qtr == Q_PHI1);
	assign cyc_phi2  = tick && (qtr == Q_PHI2);
	assign cyc_end   = tick && (qtr == Q_END);

	////////////////////////////////////////////////////////////////////////
	mbad_state_t state_reg;
	logic        res_q_reg;
	logic        res_rise;
	logic [15:0] addr_reg;
	logic [15:0] vec_base_reg;
	logic [15:0] free_addr_reg;
	logic [7:0]  wdata_reg;
	logic [7:0]  pc_hi_reg;
	logic [7:0]  data_eff;
	logic [7:0]  stack_byte;
	logic [2:0]  cnt_reg;
	logic        cur_last_reg;
	logic        cur_req_reg;
	logic        boundary_reg;
	logic        bnd;
	logic        nmi_prev_reg;
	logic        nmi_pend_reg;
	logic        irq_lvl_reg;
	logic        int_go;
	logic        take_int;
	logic        take_nmi;

	assign res_rise = (por_n && cpu_reset_n_i) && !res_q_reg;
	// in free-run test, grounded diodes pull two lines so the fetch sees clear-b
	assign data_eff = free_run_test_n_i ? data_i : (data_i & ~CLB_FORCE);
	assign int_go   = processor_stop_i && (nmi_pend_reg || (irq_lvl_reg && !mask_o));
	assign bnd      = cur_req_reg ? cur_last_reg : boundary_reg;
	assign take_int = cyc_end && (state_reg == ST_RUN) && free_run_test_n_i && bnd && int_go;
	assign take_nmi = take_int && nmi_pend_reg;

	always_comb begin
		stack_byte = regs_i.ccr;
		unique case (cnt_reg)
			3'h0: stack_byte = regs_i.pc[7:0];
			3'h1: stack_byte = regs_i.pc[15:8];
			3'h2: stack_byte = regs_i.ix[7:0];
			3'h3: stack_byte = regs_i.ix[15:8];
			3'h4: stack_byte = regs_i.acca;
			3'h5: stack_byte = regs_i.accb;
			3'h6: stack_byte = regs_i.ccr;
			default: stack_byte = regs_i.ccr;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// power-up pulse reaches the processor reset pin
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			res_q_reg     <= 1'b0;
			cpu_reset_n_o <= 1'b0;
		end else begin
			res_q_reg     <= por_n && cpu_reset_n_i;
			cpu_reset_n_o <= por_n;
		end
	end

	// interrupt inputs looked at only in phase two
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			nmi_prev_reg <= 1'b1;
			nmi_pend_reg <= 1'b0;
			irq_lvl_reg  <= 1'b0;
		end else begin
			if (cyc_phi2) begin
				nmi_prev_reg <= nonmaskable_interrupt_n_i;
				irq_lvl_reg  <= !interrupt_request_n_i && processor_stop_i;
			end
			// an edge seen at phase two of the take cycle is cleared by the take at cycle end
			if (cyc_phi2 && nmi_prev_reg && !nonmaskable_interrupt_n_i && processor_stop_i)
				nmi_pend_reg <= 1'b1;
			else if (take_nmi || !res_q_reg)
				nmi_pend_reg <= 1'b0;
		end
	end

	// mask set by restart or irq entry wins over a software clear
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			mask_o <= 1'b1;
		else if (res_rise || (take_int && !nmi_pend_reg))
			mask_o <= 1'b1;
		else if (mask_clear_i)
			mask_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: cycles issued at phase one, retired at phase two fall
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg     <= ST_RESET;
			vec_base_reg  <= VEC_RESET;
			free_addr_reg <= FREE_START;
			cnt_reg       <= 3'h0;
			boundary_reg  <= 1'b1;
			pc_hi_reg     <= 8'h0;
		end else if (!res_q_reg) begin
			state_reg <= ST_RESET;
		end else if (res_rise || state_reg == ST_RESET) begin
			state_reg    <= ST_VEC;
			vec_base_reg <= VEC_RESET;
			cnt_reg      <= 3'h0;
		end else if (cyc_end) begin
			unique case (state_reg)
				ST_VEC: begin
					if (cur_req_reg) begin
						cnt_reg   <= cnt_reg + 3'h1;
						pc_hi_reg <= data_eff;
						if (cnt_reg[0]) begin
							state_reg    <= ST_RUN;
							boundary_reg <= 1'b1;
						end
					end
				end
				ST_STACK: begin
					if (cur_req_reg) begin
						cnt_reg <= (cnt_reg == STACK_LAST) ? 3'h0 : cnt_reg + 3'h1;
						if (cnt_reg == STACK_LAST)
							state_reg <= ST_VEC;
					end
				end
				ST_FREE: begin
					if (cur_req_reg)
						free_addr_reg <= (free_addr_reg == ADDR_HIGH) ? FREE_START : free_addr_reg + 16'h1;
					if (free_run_test_n_i)
						state_reg <= ST_RUN;
				end
				ST_RUN: begin
					boundary_reg <= bnd;
					if (!free_run_test_n_i) begin
						state_reg     <= ST_FREE;
						free_addr_reg <= FREE_START;
					end else if (take_int) begin
						state_reg    <= ST_STACK;
						cnt_reg      <= 3'h0;
						vec_base_reg <= nmi_pend_reg ? VEC_NMI : VEC_IRQ;
					end
				end
				default: state_reg <= ST_RESET;
			endcase
		end
	end

	// bus cycle launch; a halted processor starts no cycle
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			addr_reg               <= ADDR_HIGH;
			addr_n_o               <= ~ADDR_HIGH;
			valid_address_strobe_o <= 1'b0;
			rw_o                   <= 1'b1;
			wdata_reg              <= 8'h0;
			cur_req_reg            <= 1'b0;
			cur_last_reg           <= 1'b0;
			req_taken_o            <= 1'b0;
		end else begin
			req_taken_o <= 1'b0;
			if (state_reg == ST_RESET || !res_q_reg) begin
				addr_reg               <= ADDR_HIGH;
				addr_n_o               <= ~ADDR_HIGH;
				valid_address_strobe_o <= 1'b0;
				rw_o                   <= 1'b1;
				cur_req_reg            <= 1'b0;
			end else if (cyc_start) begin
				valid_address_strobe_o <= 1'b0;
				rw_o                   <= 1'b1;
				cur_req_reg            <= 1'b0;
				cur_last_reg           <= 1'b0;
				if (processor_stop_i) begin
					unique case (state_reg)
						ST_VEC: begin
							addr_reg               <= vec_base_reg | {15'h0, cnt_reg[0]};
							addr_n_o               <= ~(vec_base_reg | {15'h0, cnt_reg[0]});
							valid_address_strobe_o <= 1'b1;
							cur_req_reg            <= 1'b1;
						end
						ST_STACK: begin
							addr_reg               <= regs_i.sp - {13'h0, cnt_reg};
							addr_n_o               <= ~(regs_i.sp - {13'h0, cnt_reg});
							valid_address_strobe_o <= 1'b1;
							rw_o                   <= 1'b0;
							wdata_reg              <= stack_byte;
							cur_req_reg            <= 1'b1;
						end
						ST_FREE: begin
							addr_reg               <= free_addr_reg;
							addr_n_o               <= ~free_addr_reg;
							valid_address_strobe_o <= 1'b1;
							cur_req_reg            <= 1'b1;
						end
						ST_RUN: begin
							if (req_valid_i && free_run_test_n_i) begin
								addr_reg               <= req_i.addr;
								addr_n_o               <= ~req_i.addr;
								valid_address_strobe_o <= 1'b1;
								rw_o                   <= !req_i.write;
								wdata_reg              <= req_i.wdata;
								cur_req_reg            <= 1'b1;
								cur_last_reg           <= req_i.last;
								req_taken_o            <= 1'b1;
							end
						end
						default: cur_req_reg <= 1'b0;
					endcase
				end
			end else if (cyc_end) begin
				valid_address_strobe_o <= 1'b0;
				rw_o                   <= 1'b1;
			end
		end
	end

	// answers toward the core
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rsp_valid_o     <= 1'b0;
			rsp_data_o      <= 8'h0;
			pc_load_valid_o <= 1'b0;
			pc_load_o       <= 16'h0;
		end else begin
			rsp_valid_o     <= cyc_end && cur_req_reg && state_reg == ST_RUN;
			pc_load_valid_o <= cyc_end && cur_req_reg && state_reg == ST_VEC && cnt_reg[0];
			if (cyc_end && cur_req_reg)
				rsp_data_o <= data_eff;
			if (cyc_end && cur_req_reg && state_reg == ST_VEC && cnt_reg[0])
				pc_load_o <= {pc_hi_reg, data_eff};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers; halt or three-state control floats read/write
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rw_oe_o   <= 1'b0;
			data_oe_o <= 1'b0;
			data_o    <= 8'h0;
		end else begin
			rw_oe_o   <= processor_stop_i && !three_state_ctrl_i;
			data_oe_o <= data_bus_drive_enable_i && valid_address_strobe_o && !rw_o;
			data_o    <= wdata_reg;
		end
	end

	// strobes open at phase two rise, close when phase two falls
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dev_rd_n_o             <= 8'hFF;
			dev_wr_n_o             <= 8'hFF;
			keypad_read_strobe_n_o <= 1'b1;
			xcvr_en_n_o            <= 1'b1;
			xcvr_dir_o             <= 1'b1;
			ram_sel_n_o            <= 1'b1;
			rom_sel_n_o            <= 1'b1;
		end else if (cyc_phi2 && valid_address_strobe_o) begin
			for (int i = 0; i < 8; i++) begin
				dev_rd_n_o[i] <= !(is_dev(addr_reg) && rw_o && addr_reg[2:0] == 3'(i));
				dev_wr_n_o[i] <= !(is_dev(addr_reg) && !rw_o && addr_reg[2:0] == 3'(i));
			end
			keypad_read_strobe_n_o <= !(addr_reg == KEYPAD_ADDR && rw_o);
			ram_sel_n_o            <= !is_ram(addr_reg);
			rom_sel_n_o            <= !is_rom(addr_reg, external_rom_select_n_i);
			xcvr_en_n_o            <= !(is_ram(addr_reg) || is_dev(addr_reg)
				|| is_rom(addr_reg, external_rom_select_n_i));
			xcvr_dir_o             <= rw_o;
		end else if (cyc_end || !valid_address_strobe_o) begin
			dev_rd_n_o             <= 8'hFF;
			dev_wr_n_o             <= 8'hFF;
			keypad_read_strobe_n_o <= 1'b1;
			xcvr_en_n_o            <= 1'b1;
			ram_sel_n_o            <= 1'b1;
			rom_sel_n_o            <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_RW_IDLE_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!valid_address_strobe_o |-> rw_o) else $error("rw not high while idle");
	AST_ONE_RD_STROBE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$onehot0(~dev_rd_n_o)) else $error("more than one read strobe low");
	AST_STROBE_QUAL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(dev_rd_n_o != 8'hFF || dev_wr_n_o != 8'hFF) |-> valid_address_strobe_o && (phi2_o || $past(phi2_o)))
		else $error("strobe outside phase two of valid cycle");
	AST_KEYPAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!keypad_read_strobe_n_o |-> addr_reg == KEYPAD_ADDR && rw_o && !dev_rd_n_o[0])
		else $error("keypad strobe on wrong access");
	AST_ADDR_INV: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(addr_reg) |-> addr_n_o == ~addr_reg) else $error("address pins not complemented");
	AST_RESET_ADDR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!res_q_reg |=> addr_reg == ADDR_HIGH && !valid_address_strobe_o)
		else $error("address not forced high in reset");
	AST_RW_FLOAT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(three_state_ctrl_i || !processor_stop_i) |=> !rw_oe_o) else $error("read/write driven while floated");
	AST_DATA_OE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		data_oe_o |-> $past(data_bus_drive_enable_i) && $past(!rw_o)) else $error("data driven on read");
	AST_XCVR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(xcvr_en_n_o) |-> valid_address_strobe_o && phi2_o && xcvr_dir_o == rw_o)
		else $error("transceiver enabled outside transfer");
	AST_FREE_SWEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ST_FREE && valid_address_strobe_o) |-> addr_reg[15]) else $error("free-run left upper half");
endmodule

/* File: verif/mbad_bus_model.sv */
// mbad_bus_model: rom, ram and keypad standing behind the processor bus
// assumes complemented address and low-active selects from mbad_top
`timescale 1ns/1ps
module mbad_bus_model
	import mbad_pkg::*;
#(
	parameter logic [7:0] KEY_VAL = 8'h3C
)(
	// clock
	input  wire logic        clk_i,
	// bus from the block
	input  wire logic [15:0] addr_n_i,
	input  wire logic        rw_i,
	input  wire logic        ram_sel_n_i,
	input  wire logic        rom_sel_n_i,
	input  wire logic        keypad_n_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        data_oe_i,
	// read data back
	output logic [7:0]       data_o
);
	logic [7:0]  ram [256];
	logic [7:0]  last_q = 8'h00;
	logic [15:0] addr;
	////////////////////////////////////////////////////////////////////////
	assign addr = ~addr_n_i;
	always_comb begin
		if (rw_i && !keypad_n_i)
			data_o = KEY_VAL;
		else if (rw_i && !ram_sel_n_i)
			data_o = ram[addr[7:0]];
		else if (rw_i && !rom_sel_n_i)
			data_o = addr[7:0] ^ 8'h5A;
		else
			data_o = ~last_q; // released bus: never a stale value
	end
	always_ff @(posedge clk_i) begin
		last_q <= data_o;
		if (!rw_i && !ram_sel_n_i && data_oe_i)
			ram[addr[7:0]] <= data_i;
	end
endmodule

/* File: verif/mbad_top_test.sv */
// mbad_top_test: directed bench for the bus sequencer and decoder
// assumes mbad_bus_model answers reads; rom byte is low address xor 5A
`timescale 1ns/1ps
module mbad_top_test;
	import mbad_pkg::*;
	logic        clk_i, sys_rst_i, cpu_reset_n_i, stop_i, tsc_i, dbe_i, nmi_n_i, irq_n_i;
	logic        free_n_i, xrom_n_i, req_valid_i, mask_clear_i;
	mbad_req_t   req_i;
	mbad_regs_t  regs_i;
	logic        req_taken_o, rsp_valid_o, pc_load_valid_o, mask_o, phi1_o, phi2_o, cpu_reset_n_o, blank_o;
	logic [7:0]  rsp_data_o, data_i, data_o, dev_rd_n_o, dev_wr_n_o, rd_c, wr_c;
	logic [15:0] pc_load_o, addr_n_o;
	logic        vma_o, rw_o, rw_oe_o, data_oe_o, xcvr_en_n_o, xcvr_dir_o, ram_sel_n_o, rom_sel_n_o, kp_n_o;
	logic        kp_c, rw_c, oe_c, rom_c, xc_c, dir_c, ph_c;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////////////
	mbad_top mbad_top_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_reset_n_i(cpu_reset_n_i),
		.processor_stop_i(stop_i), .three_state_ctrl_i(tsc_i), .data_bus_drive_enable_i(dbe_i),
		.nonmaskable_interrupt_n_i(nmi_n_i), .interrupt_request_n_i(irq_n_i),
		.free_run_test_n_i(free_n_i), .external_rom_select_n_i(xrom_n_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .regs_i(regs_i), .mask_clear_i(mask_clear_i),
		.req_taken_o(req_taken_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
		.pc_load_valid_o(pc_load_valid_o), .pc_load_o(pc_load_o), .mask_o(mask_o),
		.phi1_o(phi1_o), .phi2_o(phi2_o), .cpu_reset_n_o(cpu_reset_n_o), .display_blank_reset_o(blank_o),
		.addr_n_o(addr_n_o), .valid_address_strobe_o(vma_o), .rw_o(rw_o), .rw_oe_o(rw_oe_o),
		.data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .xcvr_en_n_o(xcvr_en_n_o),
		.xcvr_dir_o(xcvr_dir_o), .ram_sel_n_o(ram_sel_n_o), .rom_sel_n_o(rom_sel_n_o),
		.dev_rd_n_o(dev_rd_n_o), .dev_wr_n_o(dev_wr_n_o), .keypad_read_strobe_n_o(kp_n_o)
	);
	mbad_bus_model mbad_bus_model_inst (
		.clk_i(clk_i), .addr_n_i(addr_n_o), .rw_i(rw_o), .ram_sel_n_i(ram_sel_n_o),
		.rom_sel_n_i(rom_sel_n_o), .keypad_n_i(kp_n_o), .data_i(data_o), .data_oe_i(data_oe_o),
		.data_o(data_i)
	);
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic finish_test;
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard, run needs well under a quarter of this
	always @(posedge clk_i) begin
		cyc++;
		if (cyc >= 40000) begin
			num_errors++;
			finish_test;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] rom_b(input logic [15:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	task automatic step;
		@(posedge clk_i);
		#1;
	endtask
	// one bus cycle; strobes captured at the last phase-two clock
	task automatic bus_op(input logic wr, input logic lst, input logic [15:0] a, input logic [7:0] wd);
		int n;
		req_i = '{wr, lst, a, wd};
		req_valid_i = 1'b1;
		n = 0;
		do begin
			step;
			n++;
		end while (req_taken_o !== 1'b1 && n < 300);
		req_valid_i = 1'b0;
		chk(addr_n_o, 16'(~a));
		chk(phi1_o, 1);
		n = 0;
		while (rsp_valid_o !== 1'b1 && n < 300) begin
			if (phi2_o === 1'b1) begin
				rd_c = dev_rd_n_o;
				wr_c = dev_wr_n_o;
				kp_c = kp_n_o;
				rw_c = rw_o;
				oe_c = data_oe_o;
				rom_c = rom_sel_n_o;
				xc_c = xcvr_en_n_o;
				dir_c = xcvr_dir_o;
				ph_c = phi1_o;
			end
			step;
			n++;
		end
		chk(32'(rsp_valid_o), 1);
		chk(rw_c, !wr);
		chk(ph_c, 0);
	endtask
	task automatic wait_load(input int lim);
		int n;
		n = 0;
		// step first: a pulse left over from the previous call must not count
		do begin
			step;
			n++;
		end while (pc_load_valid_o !== 1'b1 && n < lim);
		chk(32'(pc_load_valid_o), 1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(cpu_reset_n_o, 0);
		chk(blank_o, 1);
		wait_load(3000);
		chk(pc_load_o, {rom_b(16'hFFFE), rom_b(16'hFFFF)});
		chk(mask_o, 1);
		chk({cpu_reset_n_o, blank_o}, 2'b10);
	endtask
	task automatic t_devices;
		for (int k = 0; k < 8; k++) begin
			bus_op(1'b0, 1'b1, 16'h0010 + 16'(k), 8'h00);
			chk(rd_c, 8'(~(8'h01 << k)));
			chk(kp_c, k != 0);
			if (k == 0) begin
				chk(rsp_data_o, 8'h3C);
				chk({xc_c, dir_c}, 2'b01);
			end
		end
		bus_op(1'b1, 1'b1, 16'h0015, 8'h77);
		chk({wr_c, rd_c}, 16'hDFFF);
		chk({xc_c, dir_c}, 2'b00);
	endtask
	task automatic t_ram;
		bus_op(1'b1, 1'b1, 16'h6080, 8'hA5);
		chk(oe_c, 1);
		chk({xc_c, dir_c}, 2'b00);
		bus_op(1'b1, 1'b1, 16'h60FF, 8'h5C);
		bus_op(1'b0, 1'b1, 16'h6080, 8'h00);
		chk({rsp_data_o, rd_c}, 16'hA5FF);
		chk({xc_c, dir_c}, 2'b01);
		bus_op(1'b0, 1'b1, 16'h60FF, 8'h00);
		chk(rsp_data_o, 8'h5C);
		dbe_i = 1'b0;
		bus_op(1'b1, 1'b1, 16'h6081, 8'h55);
		chk(oe_c, 0);
		dbe_i = 1'b1;
		tsc_i = 1'b1;
		repeat (3) step;
		chk(rw_oe_o, 0);
		tsc_i = 1'b0;
	endtask
	task automatic t_xrom;
		xrom_n_i = 1'b0;
		bus_op(1'b0, 1'b1, 16'h8000, 8'h00);
		chk(rom_c, 1);
		chk(xc_c, 1);
		xrom_n_i = 1'b1;
		bus_op(1'b0, 1'b1, 16'h8000, 8'h00);
		chk({rom_c, rsp_data_o}, {1'b0, rom_b(16'h8000)});
		chk(xc_c, 0);
	endtask
	task automatic t_irq;
		regs_i = '{16'h1234, 16'h5678, 16'h60F0, 8'h9A, 8'hBC, 8'hC0};
		mask_clear_i = 1'b1;
		step;
		mask_clear_i = 1'b0;
		stop_i = 1'b0;
		irq_n_i = 1'b0;
		repeat (300) step;
		chk({mask_o, rw_oe_o}, 2'b00);
		stop_i = 1'b1;
		wait_load(2000);
		chk(pc_load_o, {rom_b(16'hFFF8), rom_b(16'hFFF9)});
		chk(mask_o, 1);
		irq_n_i = 1'b1;
		chk(mbad_bus_model_inst.ram[8'hF0], 8'h34);
		chk(mbad_bus_model_inst.ram[8'hEA], 8'hC0);
	endtask
	task automatic t_nmi;
		nmi_n_i = 1'b0;
		wait_load(2000);
		chk(pc_load_o, {rom_b(16'hFFFC), rom_b(16'hFFFD)});
		nmi_n_i = 1'b1;
	endtask
	task automatic t_free;
		free_n_i = 1'b0;
		repeat (400) step;
		chk(addr_n_o[15], 0);
		chk(rsp_data_o & 8'hA0, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst_i = 1'b1;
		cpu_reset_n_i = 1'b1;
		stop_i = 1'b1;
		tsc_i = 1'b0;
		dbe_i = 1'b1;
		nmi_n_i = 1'b1;
		irq_n_i = 1'b1;
		free_n_i = 1'b1;
		xrom_n_i = 1'b1;
		req_valid_i = 1'b0;
		mask_clear_i = 1'b0;
		req_i = '0;
		regs_i = '0;
		repeat (12) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		t_reset;
		t_devices;
		t_ram;
		t_xrom;
		t_irq;
		t_nmi;
		t_free;
		finish_test;
	end
endmodule
